// file: rtl/wcw_top.sv
// Purpose: Countdown watchdog with a Wishbone register port.
// Assumes: Halt, wake and option inputs come from logic on clk_i.
// Notes:   The block's own reset pulse restores the control register; the status seen bit stays set.

// Summary of operation
// - The 7-bit counter steps down once per decrement period of 16384 clocks.
// - The counter keeps running even while the watchdog is not activated.
// - An active watchdog rolling from 40h to 3Fh drives the reset pin low for 500 ns.
// - The six low counter bits set the timeout in 64 single-decrement steps.
// - The watchdog leaves every reset disabled and, once activated, only a reset clears it.
// - Writing activation set with the guard bit clear fires a reset at once.
// - Halt while active, with the halt option set and no timebase interrupt, resets.
// - The hardware watchdog option makes the watchdog active without software.
// - A counter write never disturbs the prescaler phase.
// - The prescaler phase follows the timebase selection of the clock controller.
// - One period in every MSB/4 periods is shortened to (192+LSB)x64 clocks.
// - After reset the control register reads 7Fh.
// - Halt with the timebase interrupt enabled stops counting until wake, without reset.
module wcw_top import wcw_pkg::*; #(
  parameter int DEC_PERIOD_CYC = DEC_PERIOD_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] timebase_select_i,
  input wire logic rtc_interrupt_enable_i,
  input wire logic halt_reset_option_i,
  input wire logic hw_watchdog_option_i,
  input wire logic halt_exec_i,
  input wire logic wake_i,
  output logic halt_ok_o,
  output logic reset_pin_n_o
);

  localparam int TICK_CYC = DEC_PERIOD_CYC / PERIOD_TICKS;
  localparam logic [4:0] PULSE_LAST = 5'(RST_PULSE_CYC - 1);

  wcw_state_t state_q, state_d;
  logic [6:0] cnt_q, cnt_d;
  logic act_q, act_d;
  logic [4:0] pcnt_q, pcnt_d;
  logic seen_q, seen_d;
  logic halt_ok_q, halt_ok_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;

  logic dec;
  logic req;
  logic hit_ctrl;
  logic hit_stat;
  logic wr_ctrl;
  logic active_eff;
  logic fire;
  logic halt_rst;

  // ---------------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------------
  wcw_prescaler #(
    .TICK_CYC(TICK_CYC)
  ) u_presc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state_q == st_run),
    .tb_sel_i(timebase_select_i),
    .dec_o(dec)
  );

  // ---------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign hit_ctrl = (wb_adr_i[3:2] == ADR_CTRL[3:2]);
  assign hit_stat = (wb_adr_i[3:2] == ADR_STAT[3:2]);
  // Writes are dropped while the reset pulse runs; the bus still answers.
  assign wr_ctrl = req & wb_we_i & wb_sel_i[0] & hit_ctrl & (state_q != st_pulse);

  assign active_eff = act_q | hw_watchdog_option_i;
  // A clear guard bit under an active watchdog covers both the 40h to 3Fh
  // rollover and a software write with the guard bit low.
  assign fire = active_eff & ~cnt_q[GUARD_BIT];
  assign halt_rst = halt_exec_i & active_eff & ~rtc_interrupt_enable_i
                  & halt_reset_option_i;

  always_comb begin
    ack_d = req;
    rdat_d = rdat_q;
    if (req && !wb_we_i) begin
      if (hit_ctrl) begin
        rdat_d = {24'h000000, act_q, cnt_q};
      end else if (hit_stat) begin
        rdat_d = 32'h00000000;
        rdat_d[STAT_FROZEN] = (state_q == st_frozen);
        rdat_d[STAT_ACTIVE] = active_eff;
        rdat_d[STAT_HW] = hw_watchdog_option_i;
        rdat_d[STAT_SEEN] = seen_q;
      end else begin
        rdat_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ---------------------------------------------------------------------
  // Counter and reset sequencing
  // ---------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    act_d = act_q;
    pcnt_d = pcnt_q;
    seen_d = seen_q;
    halt_ok_d = 1'b0;
    unique case (state_q)
      st_run: begin
        if (dec) begin
          cnt_d = cnt_q - 7'h01;
        end
        if (wr_ctrl) begin
          cnt_d = wb_dat_i[6:0];
          act_d = act_q | wb_dat_i[ACT_BIT];
        end
        if (fire || halt_rst) begin
          state_d = st_pulse;
          pcnt_d = 5'h00;
          seen_d = 1'b1;
        end else if (halt_exec_i) begin
          state_d = st_frozen;
          halt_ok_d = 1'b1;
        end
      end
      st_frozen: begin
        if (wr_ctrl) begin
          cnt_d = wb_dat_i[6:0];
          act_d = act_q | wb_dat_i[ACT_BIT];
        end
        if (fire) begin
          state_d = st_pulse;
          pcnt_d = 5'h00;
          seen_d = 1'b1;
        end else if (wake_i) begin
          state_d = st_run;
        end
      end
      st_pulse: begin
        pcnt_d = pcnt_q + 5'h01;
        if (pcnt_q == PULSE_LAST) begin
          state_d = st_run;
          cnt_d = CTRL_RESET[6:0];
          act_d = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= st_run;
      cnt_q <= CTRL_RESET[6:0];
      act_q <= CTRL_RESET[ACT_BIT];
      pcnt_q <= 5'h00;
      seen_q <= 1'b0;
      halt_ok_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      act_q <= act_d;
      pcnt_q <= pcnt_d;
      seen_q <= seen_d;
      halt_ok_q <= halt_ok_d;
    end
  end

  assign reset_pin_n_o = (state_q != st_pulse);
  assign halt_ok_o = halt_ok_q;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_reset_val;
    @(posedge clk_i)
    rst_i |=> (cnt_q == CTRL_RESET[6:0]) && !act_q && reset_pin_n_o;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset value");

  property p_dec_step;
    @(posedge clk_i) disable iff (rst_i)
    (dec && state_q == st_run && !wr_ctrl && !fire && !halt_exec_i)
      |=> cnt_q == $past(cnt_q) - 7'h01;
  endproperty
  a_dec_step: assert property (p_dec_step) else $error("counter missed a step");

  property p_free_run;
    @(posedge clk_i) disable iff (rst_i)
    (dec && !active_eff && state_q == st_run && !wr_ctrl && !halt_exec_i)
      |=> (cnt_q != $past(cnt_q)) && !act_q;
  endproperty
  a_free_run: assert property (p_free_run) else $error("idle counter stalled");

  property p_rollover;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == st_run && active_eff && cnt_q == CNT_ROLL && dec && !wr_ctrl)
      |=> ##1 !reset_pin_n_o;
  endproperty
  a_rollover: assert property (p_rollover) else $error("rollover gave no reset");

  property p_pulse_len;
    @(posedge clk_i) disable iff (rst_i)
    $fell(reset_pin_n_o) |-> (!reset_pin_n_o) [*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too short");

  property p_write_load;
    @(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> (cnt_q == $past(wb_dat_i[6:0])) && (act_q == ($past(act_q) | $past(wb_dat_i[7])));
  endproperty
  a_write_load: assert property (p_write_load) else $error("write not loaded");

  property p_act_sticky;
    @(posedge clk_i) disable iff (rst_i)
    (act_q && state_q != st_pulse) |=> act_q;
  endproperty
  a_act_sticky: assert property (p_act_sticky) else $error("activation cleared");

  property p_sw_reset;
    @(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && wb_dat_i[ACT_BIT] && !wb_dat_i[GUARD_BIT]) |=> ##1 !reset_pin_n_o;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset missing");

  property p_halt_reset;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == st_run && halt_rst) |=> !reset_pin_n_o && !halt_ok_o;
  endproperty
  a_halt_reset: assert property (p_halt_reset) else $error("halt did not reset");

  property p_hw_mode;
    @(posedge clk_i) disable iff (rst_i)
    (hw_watchdog_option_i && state_q == st_run && !cnt_q[GUARD_BIT]) |=> !reset_pin_n_o;
  endproperty
  a_hw_mode: assert property (p_hw_mode) else $error("hardware watchdog idle");

  property p_frozen;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == st_frozen && !wr_ctrl && !wake_i) |=> $stable(cnt_q) && reset_pin_n_o;
  endproperty
  a_frozen: assert property (p_frozen) else $error("counter moved in halt");

  property p_active_halt;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == st_run && halt_exec_i && rtc_interrupt_enable_i && !fire)
      |=> state_q == st_frozen && halt_ok_o;
  endproperty
  a_active_halt: assert property (p_active_halt) else $error("no active halt");

  property p_pulse_end;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == st_pulse && pcnt_q == PULSE_LAST)
      |=> reset_pin_n_o && cnt_q == CTRL_RESET[6:0] && !act_q;
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("pulse end not restored");

  property p_ack_once;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");

  property p_ack_next;
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");

  property p_ctrl_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_ctrl)
      |=> wb_dat_o == {24'h000000, $past(act_q), $past(cnt_q)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_stat_read;
    @(posedge clk_i) disable iff (rst_i)
    (req && !wb_we_i && hit_stat)
      |=> wb_dat_o[STAT_HW] == $past(hw_watchdog_option_i) && wb_dat_o[STAT_ACTIVE] == $past(active_eff);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status read wrong");

  property p_quiet;
    @(posedge clk_i) disable iff (rst_i)
    (!active_eff && state_q != st_pulse) |=> reset_pin_n_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reset while disabled");

  property p_halt_ok_once;
    @(posedge clk_i) disable iff (rst_i)
    halt_ok_o |=> !halt_ok_o;
  endproperty
  a_halt_ok_once: assert property (p_halt_ok_once) else $error("halt accept held");

  property p_wake;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == st_frozen && wake_i && !fire) |=> state_q == st_run;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not resume");

  property p_pcnt_range;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == st_pulse) |-> pcnt_q <= PULSE_LAST;
  endproperty
  a_pcnt_range: assert property (p_pcnt_range) else $error("pulse counter overran");

  property p_pulse_hold;
    @(posedge clk_i) disable iff (rst_i)
    (state_q == st_pulse && pcnt_q != PULSE_LAST) |=> $stable(cnt_q) && $stable(act_q);
  endproperty
  a_pulse_hold: assert property (p_pulse_hold) else $error("state moved in pulse");

endmodule

// file: rtl/wcw_pkg.sv
// Purpose: Shared constants, types and lookups of the countdown watchdog.
// Assumes: The system clock is the oscillator clock that feeds the prescaler.
// Notes:   Offsets are byte addresses on a 32-bit classic Wishbone slave.

package wcw_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_PULSE_NS = 500;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 RST_PULSE_NS / CLK_PERIOD_NS;
  localparam int DEC_PERIOD_CYC_DEF = 16384;
  localparam int PERIOD_TICKS = 256;
  localparam int SHORT_BASE_TICKS = 192;
  localparam int MIN_LSB = 35;
  localparam int STEP_ACC = 4;

  // ---------------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------------
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [7:0] CTRL_RESET = 8'h7F;
  localparam logic [6:0] CNT_ROLL = 7'h40;
  localparam int ACT_BIT = 7;
  localparam int GUARD_BIT = 6;
  localparam int STAT_FROZEN = 0;
  localparam int STAT_ACTIVE = 1;
  localparam int STAT_HW = 2;
  localparam int STAT_SEEN = 3;

  typedef enum logic [2:0] {
    st_run = 3'b001,
    st_frozen = 3'b010,
    st_pulse = 3'b100
  } wcw_state_t;

  // Ticks added to 192 for the length of the shortened decrement period per timebase selection.
  function automatic logic [7:0] tb_lsb(input logic [1:0] sel);
    case (sel)
      2'h0: tb_lsb = 8'h3B;
      2'h1: tb_lsb = 8'h35;
      2'h2: tb_lsb = 8'h23;
      default: tb_lsb = 8'h36;
    endcase
  endfunction

  // Timebase period constant; one short period falls in every MSB/4 periods.
  function automatic logic [6:0] tb_msb(input logic [1:0] sel);
    case (sel)
      2'h0: tb_msb = 7'h04;
      2'h1: tb_msb = 7'h08;
      2'h2: tb_msb = 7'h14;
      default: tb_msb = 7'h31;
    endcase
  endfunction

endpackage

// file: rtl/wcw_prescaler.sv
// Purpose: Free-running prescaler that paces the watchdog counter.
// Assumes: run_i is low while the device sits in halt or active-halt and during the reset pulse.
// Notes:   Its phase is never cleared by a register write.

module wcw_prescaler import wcw_pkg::*; #(
  parameter int TICK_CYC = 64
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [1:0] tb_sel_i,
  output logic dec_o
);

  localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);
  localparam int FULL_CYC = TICK_CYC * PERIOD_TICKS;
  localparam int SHORT_MIN_CYC = TICK_CYC * (SHORT_BASE_TICKS + MIN_LSB);

  logic [11:0] sub_q, sub_d;
  logic [8:0] per_q, per_d;
  logic [6:0] acc_q, acc_d;
  logic short_q, short_d;
  logic dec_q, dec_d;
  logic [8:0] len;
  logic [6:0] acc_n;

  // ---------------------------------------------------------------------
  // Period sequencing
  // ---------------------------------------------------------------------
  always_comb begin
    sub_d = sub_q;
    per_d = per_q;
    acc_d = acc_q;
    short_d = short_q;
    dec_d = 1'b0;
    acc_n = acc_q + 7'(STEP_ACC);
    len = short_q ? 9'(SHORT_BASE_TICKS) + {1'b0, tb_lsb(tb_sel_i)}
                  : 9'(PERIOD_TICKS);
    if (run_i) begin
      if (sub_q == TICK_LAST) begin
        sub_d = 12'h000;
        if (per_q >= len - 9'h001) begin
          per_d = 9'h000;
          dec_d = 1'b1;
          if (acc_n >= tb_msb(tb_sel_i)) begin
            short_d = 1'b1;
            acc_d = acc_n - tb_msb(tb_sel_i);
          end else begin
            short_d = 1'b0;
            acc_d = acc_n;
          end
        end else begin
          per_d = per_q + 9'h001;
        end
      end else begin
        sub_d = sub_q + 12'h001;
      end
    end
  end

  // No write input reaches this counter, so its phase is unknown to software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sub_q <= 12'h000;
      per_q <= 9'h000;
      acc_q <= 7'h00;
      short_q <= 1'b0;
      dec_q <= 1'b0;
    end else begin
      sub_q <= sub_d;
      per_q <= per_d;
      acc_q <= acc_d;
      short_q <= short_d;
      dec_q <= dec_d;
    end
  end

  assign dec_o = dec_q;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  logic [15:0] gap_q;
  logic seen_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else if (dec_q) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b1;
    end else if (run_i) begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  property p_gap_max;
    @(posedge clk_i) disable iff (rst_i)
    dec_q |-> (32'(gap_q) <= FULL_CYC);
  endproperty
  a_gap_max: assert property (p_gap_max) else $error("decrement period too long");

  property p_gap_min;
    @(posedge clk_i) disable iff (rst_i)
    (dec_q && seen_q) |-> (32'(gap_q) + 1 >= SHORT_MIN_CYC);
  endproperty
  a_gap_min: assert property (p_gap_min) else $error("decrement period too short");

endmodule

// file: testbench/tb_wcw_top.sv
// Purpose: Self-checking bench of the countdown watchdog through its bus and side pins.
// Assumes: A short decrement period of 512 clocks; expectations follow from it.
// Notes:   Register reads poll every three clocks, so timing checks allow three clocks of slack.
module tb_wcw_top;
  timeunit 1ns;
  timeprecision 1ns;
  import wcw_pkg::*;
  // --------------------------------------------------------------------
  // Signals and reference values
  // --------------------------------------------------------------------
  localparam int DEC = 512;
  localparam int TICK = DEC / 256;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [1:0] timebase_select_i = 2'h0;
  logic rtc_interrupt_enable_i = 1'b0;
  logic halt_reset_option_i = 1'b0;
  logic hw_watchdog_option_i = 1'b0;
  logic halt_exec_i = 1'b0;
  logic wake_i = 1'b0;
  logic halt_ok_o;
  logic reset_pin_n_o;
  int failures = 0;
  int tests_run = 0;
  int seed = 96632;
  int lsb_t[4] = '{59, 53, 35, 54};
  int t0, t1, d, s, k;
  logic [31:0] rd_q;
  logic [7:0] v0;

  wcw_top #(.DEC_PERIOD_CYC(DEC)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timebase_select_i(timebase_select_i), .rtc_interrupt_enable_i(rtc_interrupt_enable_i),
    .halt_reset_option_i(halt_reset_option_i), .hw_watchdog_option_i(hw_watchdog_option_i),
    .halt_exec_i(halt_exec_i), .wake_i(wake_i), .halt_ok_o(halt_ok_o),
    .reset_pin_n_o(reset_pin_n_o));

  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      failures++;
    end
  endtask

  function automatic int now();
    return int'($time / 20);
  endfunction

  // Classic single Wishbone cycle; random upper data and sel bits must be ignored.
  task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] dat);
    int n;
    logic [31:0] r;
    r = $random(seed);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= {r[3:1], 1'b1};
    wb_dat_i <= {r[31:8], dat};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      complete_run();
    end
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic rst_pulse();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // Returns the time at which the counter value next changes.
  task automatic wait_dec(output int t);
    int n;
    logic [6:0] w;
    bus(1'b0, ADR_CTRL, 8'h00);
    w = rd_q[6:0];
    n = 0;
    do begin
      bus(1'b0, ADR_CTRL, 8'h00);
      n++;
    end while (rd_q[6:0] === w && n < 3000);
    if (n >= 3000) begin
      failures++;
      complete_run();
    end
    chk("counter step", 32'(w - 7'h01), rd_q[6:0]);
    t = now();
  endtask

  // Waits up to bound clocks for the reset pin, then measures its low time.
  task automatic pin_pulse(input int bound, output int dly);
    int n;
    n = 0;
    while (reset_pin_n_o !== 1'b0 && n < bound) begin
      @(posedge clk_i);
      n++;
    end
    dly = n;
    chk("reset pin low", 32'h0, reset_pin_n_o);
    n = 0;
    while (reset_pin_n_o === 1'b0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk("pulse length", RST_PULSE_CYC, n);
    bus(1'b0, ADR_CTRL, 8'h00);
    chk("ctrl after pulse", 32'h1, rd_q[7:0] == 8'h7F || rd_q[7:0] == 8'h7E);
  endtask

  function automatic logic gap_ok(input int g, input int sel);
    int sh;
    sh = (192 + lsb_t[sel]) * TICK;
    return (g >= DEC - 3 && g <= DEC + 3) || (g >= sh - 3 && g <= sh + 3);
  endfunction

  task automatic halt_now();
    @(posedge clk_i);
    halt_exec_i <= 1'b1;
    @(posedge clk_i);
    halt_exec_i <= 1'b0;
  endtask

  task automatic halt_accepted();
    int n;
    n = 0;
    while (halt_ok_o !== 1'b1 && n < 3) begin
      @(posedge clk_i);
      n++;
    end
    chk("halt accepted", 32'h1, halt_ok_o);
    chk("no reset on halt", 32'h1, reset_pin_n_o);
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  initial begin
    rst_pulse();
    bus(1'b0, ADR_CTRL, 8'h00);
    chk("ctrl reset", 32'h7F, rd_q);
    bus(1'b0, ADR_STAT, 8'h00);
    chk("status reset", 32'h0, rd_q);
    bus(1'b1, 4'h8, 8'hA5);
    bus(1'b0, 4'h8, 8'h00);
    chk("unmapped", 32'h0, rd_q);
    bus(1'b1, ADR_STAT, 8'hFF);
    bus(1'b0, ADR_STAT, 8'h00);
    chk("status read only", 32'h0, rd_q);
    $display("test reset values done");
    for (s = 0; s < 4; s++) begin
      timebase_select_i <= s[1:0];
      wait_dec(t0);
      for (k = 0; k < 3; k++) begin
        wait_dec(t1);
        chk("decrement gap", 32'h1, gap_ok(t1 - t0, s));
        chk("inactive", 32'h0, rd_q[7]);
        t0 = t1;
      end
    end
    $display("test free running done");
    wait_dec(t0);
    repeat (50) @(posedge clk_i);
    bus(1'b1, ADR_CTRL, 8'h7F);
    bus(1'b0, ADR_CTRL, 8'h00);
    chk("loaded", 32'h7F, rd_q);
    wait_dec(t1);
    chk("phase kept", 32'h1, gap_ok(t1 - t0, 3));
    $display("test prescaler phase done");
    bus(1'b1, ADR_CTRL, 8'hFF);
    bus(1'b1, ADR_CTRL, 8'h7F);
    bus(1'b0, ADR_CTRL, 8'h00);
    chk("activation sticks", 32'h1, rd_q[7]);
    bus(1'b0, ADR_STAT, 8'h00);
    chk("status active", 32'h1, rd_q[STAT_ACTIVE]);
    for (k = 0; k < 3; k++) begin
      bus(1'b1, ADR_CTRL, 8'hC0 | k[7:0]);
      t0 = now();
      pin_pulse(3000, d);
      chk("timeout max", 32'h1, d <= (k + 1) * DEC + 4);
      chk("timeout min", 32'h1, d >= k * (192 + 54) * TICK);
    end
    $display("test timeout done");
    bus(1'b1, ADR_CTRL, 8'h3F);
    repeat (4) @(posedge clk_i);
    chk("disabled no reset", 32'h1, reset_pin_n_o);
    bus(1'b1, ADR_CTRL, 8'h80);
    pin_pulse(5, d);
    $display("test software reset done");
    rst_pulse();
    hw_watchdog_option_i <= 1'b1;
    bus(1'b1, ADR_CTRL, 8'h3F);
    pin_pulse(5, d);
    bus(1'b0, ADR_STAT, 8'h00);
    chk("status hw", 32'h1, rd_q[STAT_HW]);
    hw_watchdog_option_i <= 1'b0;
    $display("test hardware option done");
    bus(1'b1, ADR_CTRL, 8'hFF);
    halt_reset_option_i <= 1'b1;
    halt_now();
    pin_pulse(5, d);
    bus(1'b1, ADR_CTRL, 8'hFF);
    halt_reset_option_i <= 1'b0;
    halt_now();
    halt_accepted();
    bus(1'b0, ADR_CTRL, 8'h00);
    v0 = rd_q[7:0];
    repeat (1200) @(posedge clk_i);
    bus(1'b0, ADR_CTRL, 8'h00);
    chk("frozen counter", v0, rd_q);
    bus(1'b0, ADR_STAT, 8'h00);
    chk("status frozen", 32'h1, rd_q[STAT_FROZEN]);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    wait_dec(t0);
    rtc_interrupt_enable_i <= 1'b1;
    halt_reset_option_i <= 1'b1;
    halt_now();
    halt_accepted();
    $display("test halt done");
    complete_run();
  end
endmodule
